// >>> src/svid_telemetry_id_register_bank.sv
// identity, status and telemetry registers behind the serial voltage-id link
//
// Overview of operation
// [R01] maker code read at index 00h
// [R02] part code read at index 01h
// [R03] revision at 02h, date code at 03h
// [R04] protocol version 01h at index 05h
// [R05] feature flags D7h at index 06h
// [R06] bit 7 set: full scale is maximum current
// [R07] temperature, power, voltage, current supported; inputs not
// [R08] primary status at 10h, read after alert
// [R09] secondary status at 11h, resets to 00h
// [R10] temperature zones reported at index 12h
// [R11] current conversion at 15h, FFh at 2 V
// [R12] output voltage at 16h, 8 mV per count
// [R13] temperature at 17h in degrees, zero unsupported
// [R14] power at 18h is voltage times current
// [R15] writes leave read-only registers unchanged
`include "svid_bank_params.svh"

module svid_telemetry_id_register_bank #(
    // arbitrary neutral identity values
    parameter logic [7:0] MAKER_ID = 8'h5c,
    parameter logic [7:0] PART_ID = 8'h3e,
    parameter logic [7:0] PART_REV = 8'h00,
    parameter logic [7:0] DATE_CODE = 8'h00,
    // temperature zone ladder
    parameter int ZONE_TOP = `ZONE_TOP_DEG,
    parameter int ZONE_STEP = `ZONE_STEP_DEG,
    // power word scaling
    parameter int POWER_SHIFT = `PWR_SHIFT
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // register access from the link engine
    input wire logic [7:0] reg_index,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_done,
    output logic reg_hit,
    // converter samples, held steady across an update toggle
    input wire logic [7:0] adc_iout,
    input wire logic [7:0] adc_vout,
    input wire logic [7:0] adc_temp,
    input wire logic adc_update,
    // condition inputs from the analog side
    input wire logic [7:0] cond_primary,
    input wire logic [7:0] cond_secondary,
    // alert line, low while new primary status waits
    output logic alert_n
);

    ////////////////////////////////////////////////////////////////
    // parameter checks

    // the lowest zone threshold must stay at or above zero degrees
    if (ZONE_STEP < 0 || ZONE_STEP * 7 > ZONE_TOP) begin : g_chk_zone
        $error("register bank: zone ladder does not fit");
    end
    // thresholds are compared against an 8-bit reading
    if (ZONE_TOP > 255) begin : g_chk_top
        $error("register bank: zone top above 8 bits");
    end

    ////////////////////////////////////////////////////////////////
    // declarations

    svid_bank_pkg::bank_state_t state_r;
    svid_bank_pkg::bank_state_t state_nxt;
    logic [7:0] power_code;
    logic power_valid;
    logic [7:0] zone_hit;
    logic [7:0] samp_iout;
    logic [7:0] samp_vout;
    logic [7:0] samp_temp;
    logic samp_take;
    logic stat1_read;
    logic stat1_change;
    logic [7:0] rd_value;
    logic rd_mapped;
    logic [7:0] wr_unused;

    ////////////////////////////////////////////////////////////////
    // reset image of the state

    // telemetry starts at 01h so it never reads as unsupported
    // a constant, so the asynchronous reset branch loads no logic output
    localparam svid_bank_pkg::bank_state_t STATE_RST = '{
        iout: `RST_TELEMETRY,
        vout: `RST_TELEMETRY,
        temp: `RST_TELEMETRY,
        stat1: `RST_STATUS,
        stat2: `RST_STATUS, // R09
        zone: `RST_ZONE,
        default: '0
    };

    ////////////////////////////////////////////////////////////////
    // fields of the synchronised sample word

    // only the second stage of the sample pipe is looked at
    assign samp_iout = state_r.samp_s2[`SAMP_IOUT_LSB +: 8];
    assign samp_vout = state_r.samp_s2[`SAMP_VOUT_LSB +: 8];
    assign samp_temp = state_r.samp_s2[`SAMP_TEMP_LSB +: 8];

    // a new sample lands once the toggle edge clears the synchroniser
    assign samp_take = state_r.tgl_s2 ^ state_r.tgl_s3;

    ////////////////////////////////////////////////////////////////
    // temperature zone ladder

    // one comparator per zone bit, top bit at the limit temperature
    for (genvar i = 0; i < 8; i++) begin : g_zone
        localparam int TH = ZONE_TOP - (7 - i) * ZONE_STEP;
        assign zone_hit[i] = (state_r.temp >= TH[7:0]); // R10
    end

    ////////////////////////////////////////////////////////////////
    // primary status and alert

    // a read of the primary status is what releases the alert
    assign stat1_read = reg_rd && (reg_index == `IDX_STATUS_PRI);
    assign stat1_change = (state_r.st1_s2 != state_r.stat1);

    ////////////////////////////////////////////////////////////////
    // read decode

    // unmapped indexes read as zero and drop the hit flag
    always_comb begin
        rd_value = 8'h00;
        rd_mapped = 1'b1;
        if (reg_index == `IDX_MAKER_ID) begin
            rd_value = MAKER_ID; // R01
        end else if (reg_index == `IDX_PART_ID) begin
            rd_value = PART_ID; // R02
        end else if (reg_index == `IDX_PART_REV) begin
            rd_value = PART_REV; // R03
        end else if (reg_index == `IDX_DATE_CODE) begin
            rd_value = DATE_CODE; // R03
        end else if (reg_index == `IDX_PROTOCOL) begin
            rd_value = `VAL_PROTOCOL; // R04
        end else if (reg_index == `IDX_FEATURES) begin
            rd_value = `VAL_FEATURES; // R05 R06 R07
        end else if (reg_index == `IDX_STATUS_PRI) begin
            rd_value = state_r.stat1; // R08
        end else if (reg_index == `IDX_STATUS_SEC) begin
            rd_value = state_r.stat2; // R09
        end else if (reg_index == `IDX_ZONE) begin
            rd_value = state_r.zone; // R10
        end else if (reg_index == `IDX_IOUT) begin
            rd_value = state_r.iout; // R11
        end else if (reg_index == `IDX_VOUT) begin
            rd_value = state_r.vout; // R12
        end else if (reg_index == `IDX_TEMP) begin
            rd_value = state_r.temp; // R13
        end else if (reg_index == `IDX_POWER) begin
            rd_value = power_code; // R14
        end else begin
            rd_mapped = 1'b0;
        end
    end

    // write data is accepted and dropped: every register here is read-only
    assign wr_unused = reg_wdata; // R15

    ////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        state_nxt = state_r;

        // two-stage synchronisers for everything from the analog side
        state_nxt.tgl_s1 = adc_update;
        state_nxt.tgl_s2 = state_r.tgl_s1;
        state_nxt.tgl_s3 = state_r.tgl_s2;
        state_nxt.samp_s1 = {adc_temp, adc_vout, adc_iout};
        state_nxt.samp_s2 = state_r.samp_s1;
        state_nxt.st1_s1 = cond_primary;
        state_nxt.st1_s2 = state_r.st1_s1;
        state_nxt.st2_s1 = cond_secondary;
        state_nxt.st2_s2 = state_r.st2_s1;

        // telemetry capture on each converter update
        state_nxt.pwr_go = samp_take;
        if (samp_take) begin
            // current: converter already scales 2 V to FFh
            state_nxt.iout = samp_iout; // R11
            // voltage: one count per 8 mV of differential sense
            state_nxt.vout = samp_vout; // R12
            // temperature: zero is reserved, so a real 0 C reads 01h
            if (samp_temp == `VAL_UNSUPPORTED) begin
                state_nxt.temp = `VAL_FLOOR; // R13
            end else begin
                state_nxt.temp = samp_temp; // R13
            end
        end

        // zone flags follow the held temperature
        state_nxt.zone = zone_hit; // R10

        // status registers mirror the synchronised conditions
        state_nxt.stat1 = state_r.st1_s2; // R08
        state_nxt.stat2 = state_r.st2_s2; // R09

        // alert: a change sets it, a primary read clears it, set wins
        if (stat1_change) begin
            state_nxt.alert = 1'b1; // R08
        end else if (stat1_read) begin
            state_nxt.alert = 1'b0; // R08
        end

        // answer to every read or write one cycle later
        state_nxt.done = reg_rd || reg_wr;
        state_nxt.hit = (reg_rd || reg_wr) && rd_mapped;
        if (reg_rd) begin
            state_nxt.rdata = rd_mapped ? rd_value : 8'h00;
        end else if (reg_wr) begin
            // a write returns nothing and changes nothing
            state_nxt.rdata = 8'h00; // R15
        end
    end

    ////////////////////////////////////////////////////////////////
    // state register

    // clock enable low freezes every field, synchronisers included
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= STATE_RST;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // power helper

    // product recomputed the cycle after each new sample is held
    output_power_calc #(
        .SHIFT(POWER_SHIFT)
    ) u_power (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .vout_code(state_r.vout),
        .iout_code(state_r.iout),
        .go(state_r.pwr_go),
        .power_code(power_code),
        .power_valid(power_valid)
    );

    ////////////////////////////////////////////////////////////////
    // outputs

    // all outputs straight from flops
    assign reg_rdata = state_r.rdata;
    assign reg_done = state_r.done;
    assign reg_hit = state_r.hit;
    assign alert_n = ~state_r.alert; // R08

endmodule

// >>> src/svid_bank_params.svh
// constants of the telemetry and identity register bank
`ifndef SVID_BANK_PARAMS_SVH
`define SVID_BANK_PARAMS_SVH

// register indexes as seen on the serial link
`define IDX_MAKER_ID 8'h00
`define IDX_PART_ID 8'h01
`define IDX_PART_REV 8'h02
`define IDX_DATE_CODE 8'h03
`define IDX_PROTOCOL 8'h05
`define IDX_FEATURES 8'h06
`define IDX_STATUS_PRI 8'h10
`define IDX_STATUS_SEC 8'h11
`define IDX_ZONE 8'h12
`define IDX_IOUT 8'h15
`define IDX_VOUT 8'h16
`define IDX_TEMP 8'h17
`define IDX_POWER 8'h18

// fixed values and reset values
`define VAL_PROTOCOL 8'h01
`define VAL_FEATURES 8'hd7
`define RST_STATUS 8'h00
`define RST_ZONE 8'h00
`define RST_TELEMETRY 8'h01
`define VAL_UNSUPPORTED 8'h00
`define VAL_FLOOR 8'h01

// feature flag bit positions
`define FEAT_IOUT_FMT 7
`define FEAT_TEMP 6

// packing of the converter sample word
`define SAMP_IOUT_LSB 0
`define SAMP_VOUT_LSB 8
`define SAMP_TEMP_LSB 16
`define SAMP_W 24

// zone thresholds in degrees, top zone at the limit
`define ZONE_TOP_DEG 100
`define ZONE_STEP_DEG 3

// power scaling: product shifted right by this
`define PWR_SHIFT 8

`endif

// >>> src/svid_bank_pkg.sv
// types shared by the register bank and its power helper
package svid_bank_pkg;

    // whole state of the bank
    typedef struct packed {
        logic tgl_s1;
        logic tgl_s2;
        logic tgl_s3;
        logic [23:0] samp_s1;
        logic [23:0] samp_s2;
        logic [7:0] st1_s1;
        logic [7:0] st1_s2;
        logic [7:0] st2_s1;
        logic [7:0] st2_s2;
        logic [7:0] iout;
        logic [7:0] vout;
        logic [7:0] temp;
        logic [7:0] stat1;
        logic [7:0] stat2;
        logic [7:0] zone;
        logic pwr_go;
        logic alert;
        logic [7:0] rdata;
        logic done;
        logic hit;
    } bank_state_t;

    // whole state of the power helper
    typedef struct packed {
        logic [7:0] power;
        logic valid;
    } power_state_t;

endpackage

// >>> src/output_power_calc.sv
// output power word from voltage and current readings
`include "svid_bank_params.svh"

module output_power_calc #(
    parameter int SHIFT = `PWR_SHIFT
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // readings in
    input wire logic [7:0] vout_code,
    input wire logic [7:0] iout_code,
    input wire logic go,
    // result out
    output logic [7:0] power_code,
    output logic power_valid
);
    svid_bank_pkg::power_state_t state_r;
    svid_bank_pkg::power_state_t state_nxt;
    logic [15:0] product;

    // shift must leave an 8-bit window inside the product
    if (SHIFT < 0 || SHIFT > 8) begin : g_chk
        $error("output_power_calc: SHIFT out of range");
    end

    // full product, then the window; zero is reserved for "unsupported"
    always_comb begin
        state_nxt = state_r;
        product = 16'(vout_code * iout_code) >> SHIFT;
        state_nxt.valid = go;
        if (go) begin
            state_nxt.power = (product[7:0] == `VAL_UNSUPPORTED) ? `VAL_FLOOR : product[7:0]; // R14
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= '{power: `RST_TELEMETRY, valid: 1'b0};
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    assign power_code = state_r.power;
    assign power_valid = state_r.valid;
endmodule

// >>> sim/bank_props.sv
// concurrent checks on the register bank ports
module bank_props (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // register port
    input wire logic [7:0] reg_index,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_done,
    input wire logic reg_hit,
    // status side
    input wire logic [7:0] cond_primary,
    input wire logic alert_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////
    // answer timing and fixed values
    a_done_follows: assert property (clk_en && (reg_rd || reg_wr) |=> reg_done)
        else $error("no answer after request");
    a_no_stray_done: assert property (clk_en && !(reg_rd || reg_wr) |=> !reg_done)
        else $error("answer without request");
    a_feature_read: assert property (reg_rd && reg_index == 8'h06 |=> reg_rdata == 8'hd7)
        else $error("feature flags wrong");
    a_proto_read: assert property (reg_rd && reg_index == 8'h05 |=> reg_rdata == 8'h01)
        else $error("protocol version wrong");
    a_unmapped_read: assert property (reg_rd && reg_index > 8'h18 |=> !reg_hit && reg_rdata == 8'h00)
        else $error("unmapped index answered");
    a_write_no_data: assert property (reg_wr && !reg_rd |=> reg_hit ? reg_rdata == 8'h00 : 1'b1)
        else $error("write returned data");
    // zero means unsupported, so temperature and power readings never read zero
    a_reading_nonzero: assert property (reg_rd && reg_index inside {8'h17, 8'h18}
        |=> reg_rdata != 8'h00)
        else $error("telemetry reads zero");
    // alert falls three edges after a settled change
    a_alert_delay: assert property (clk_en && $changed(cond_primary)
        ##1 (clk_en && $stable(cond_primary)) [*2] |=> !alert_n)
        else $error("alert late");
    a_alert_clear: assert property ($stable(cond_primary) [*4] ##0
        (clk_en && !alert_n && reg_rd && reg_index == 8'h10) |=> alert_n)
        else $error("alert not cleared");

    // main scenarios
    c_alert: cover property ($fell(alert_n));
    c_write: cover property (reg_wr ##1 reg_done);
    c_status: cover property (reg_rd && reg_index == 8'h10 && !alert_n);
endmodule

bind svid_telemetry_id_register_bank bank_props i_bank_props (.sys_clk(sys_clk),
    .rst_n(rst_n), .clk_en(clk_en), .reg_index(reg_index), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata), .reg_done(reg_done), .reg_hit(reg_hit),
    .cond_primary(cond_primary), .alert_n(alert_n));

// >>> sim/bus_master_model.sv
// bus master model: register accesses and alert service
module bus_master_model (
    // clock
    input wire logic sys_clk,
    // request side
    output logic [7:0] reg_index,
    output logic reg_rd,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    // answer side
    input wire logic [7:0] reg_rdata,
    input wire logic reg_done,
    input wire logic reg_hit,
    input wire logic alert_n
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle request lines
    initial begin
        reg_index = 8'h00;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end

    // request held for the taking edge, answer read just after it
    task automatic access(input logic rd, wr, input logic [7:0] idx, wd,
                          output logic [7:0] rdata, output logic hit, done);
        @(posedge sys_clk);
        #1;
        reg_rd = rd;
        reg_wr = wr;
        reg_index = idx;
        reg_wdata = wd;
        @(posedge sys_clk);
        #1;
        rdata = reg_rdata;
        hit = reg_hit;
        done = reg_done;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        // released lines carry junk, not the old value
        reg_index = ~idx;
        reg_wdata = ~wd;
    endtask

    // primary status is read only once the alert is seen low
    task automatic service_alert(output logic [7:0] st, output logic ok);
        logic h, d;
        ok = 1'b0;
        st = 8'h00;
        for (int n = 0; n < 20 && !ok; n++) begin
            @(posedge sys_clk);
            #1;
            ok = (alert_n === 1'b0);
        end
        if (ok) access(1'b1, 1'b0, 8'h10, 8'h00, st, h, d);
    endtask
endmodule

// >>> sim/testbench.sv
// self-checking bench of the telemetry and identity register bank
`include "svid_bank_params.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] MAKER = 8'ha7; // arbitrary value
    localparam logic [7:0] PART = 8'h4b; // arbitrary value
    localparam logic [7:0] IDX [17] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06,
        8'h10, 8'h11, 8'h12, 8'h15, 8'h16, 8'h17, 8'h18, 8'h04, 8'h13, 8'h20, 8'hff};
    localparam logic [7:0] TEMPS [6] = '{8'h64, 8'h00, 8'h5e, 8'h61, 8'h5b, 8'hff};
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] reg_index, reg_wdata, reg_rdata, adc_iout, adc_vout, adc_temp;
    logic [7:0] cond_primary, cond_secondary, rd, m_iout, m_vout, m_temp, m_pwr, m_zone;
    logic reg_rd, reg_wr, reg_done, reg_hit, adc_update, alert_n, hit, dn, ok;
    int error_cnt = 0;
    int n_checks = 0;

    // 20 MHz clock
    always #25 sys_clk = ~sys_clk;

    svid_telemetry_id_register_bank #(.MAKER_ID(MAKER), .PART_ID(PART))
    i_svid_telemetry_id_register_bank (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
        .reg_index(reg_index), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_done(reg_done), .reg_hit(reg_hit),
        .adc_iout(adc_iout), .adc_vout(adc_vout), .adc_temp(adc_temp),
        .adc_update(adc_update), .cond_primary(cond_primary),
        .cond_secondary(cond_secondary), .alert_n(alert_n));

    bus_master_model i_bus_master_model (.sys_clk(sys_clk), .reg_index(reg_index),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_done(reg_done), .reg_hit(reg_hit), .alert_n(alert_n));

    ////////////////////////////////////////////////////////////////
    // reference model of the register map
    function automatic logic [7:0] exp_val(input logic [7:0] i);
        case (i)
            8'h00: return MAKER;
            8'h01: return PART;
            8'h05: return 8'h01;
            8'h06: return 8'hd7;
            8'h10: return cond_primary;
            8'h11: return cond_secondary;
            8'h12: return m_zone;
            8'h15: return m_iout;
            8'h16: return m_vout;
            8'h17: return m_temp;
            8'h18: return m_pwr;
            default: return 8'h00;
        endcase
    endfunction

    // one read compared with the model
    task automatic chk_reg(input logic [7:0] i);
        i_bus_master_model.access(1'b1, 1'b0, i, 8'h00, rd, hit, dn);
        `CHK(dn, 1'b1)
        `CHK(hit, 1'(i inside {[8'h00:8'h03], 8'h05, 8'h06, [8'h10:8'h12], [8'h15:8'h18]}))
        `CHK(rd, exp_val(i))
    endtask

    // new converter sample; zero temperature and power are floored to 01
    task automatic sample(input logic [7:0] i, v, t);
        int p;
        @(posedge sys_clk);
        #1;
        adc_iout = i;
        adc_vout = v;
        adc_temp = t;
        adc_update = ~adc_update;
        p = (int'(v) * int'(i)) >> `PWR_SHIFT;
        m_iout = i;
        m_vout = v;
        m_temp = (t == 8'h00) ? 8'h01 : t;
        m_pwr = (p == 0) ? 8'h01 : 8'(p);
        for (int b = 0; b < 8; b++) begin
            m_zone[b] = int'(m_temp) >= `ZONE_TOP_DEG - (7 - b) * `ZONE_STEP_DEG;
        end
        repeat (8) @(posedge sys_clk);
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        {adc_iout, adc_vout, adc_temp, cond_primary, cond_secondary} = '0;
        adc_update = 1'b0;
        {m_iout, m_vout, m_temp, m_pwr} = {4{8'h01}};
        m_zone = 8'h00;
        void'($urandom(67));
        repeat (3) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        // reset values, identity and unmapped places
        for (int k = 0; k < 17; k++) chk_reg(IDX[k]);
        // writes are answered yet change nothing
        for (int k = 0; k < 17; k++) begin
            i_bus_master_model.access(1'b0, 1'b1, IDX[k], 8'($urandom), rd, hit, dn);
            `CHK(dn, 1'b1)
            `CHK(rd, 8'h00)
            chk_reg(IDX[k]);
        end
        // telemetry samples, zero cases included
        for (int k = 0; k < 6; k++) begin
            sample((k == 1) ? 8'h00 : 8'($urandom), 8'($urandom), TEMPS[k]);
            for (int i = 8'h12; i <= 8'h18; i++) chk_reg(8'(i));
        end
        // primary status change raises the alert, reading clears it
        for (int k = 0; k < 3; k++) begin
            @(posedge sys_clk);
            #1;
            cond_primary = cond_primary ^ (8'($urandom) | 8'h01);
            cond_secondary = 8'($urandom);
            i_bus_master_model.service_alert(rd, ok);
            `CHK(ok, 1'b1)
            // a lost alert ends the run at the report
            if (!ok) break;
            `CHK(rd, cond_primary)
            `CHK(alert_n, 1'b1)
            chk_reg(8'h11);
        end
        // clock enable low freezes the status pipe, so no alert yet
        if (ok) begin
            @(posedge sys_clk);
            #1;
            clk_en = 1'b0;
            cond_primary = ~cond_primary;
            repeat (6) @(posedge sys_clk);
            #1;
            `CHK(alert_n, 1'b1)
            clk_en = 1'b1;
            i_bus_master_model.service_alert(rd, ok);
            `CHK(ok, 1'b1)
            `CHK(rd, cond_primary)
        end
        complete_run();
    end
endmodule
